// file: rtl/blank_chop_defs.svh
`ifndef BLANK_CHOP_DEFS_SVH
`define BLANK_CHOP_DEFS_SVH
// Register word addresses
`define ADDR_BLANK_CTRL 4'h0
`define ADDR_BLANK_DELAY 4'h1
`define ADDR_AUX_CTRL 4'h2
// Blanking control fields
`define BC_PHR 15
`define BC_PHF 14
`define BC_PLR 13
`define BC_PLF 12
`define BC_FLT_EN 11
`define BC_CL_EN 10
`define BC_SEL_HIGH 5
`define BC_SEL_LOW 4
`define BC_BPHH 3
`define BC_BPHL 2
`define BC_BPLH 1
`define BC_BPLL 0
`define BC_MASK 16'hfc3f
// Delay register fields
`define DLY_MASK 16'h0fff
`define DLY_W 12
// Auxiliary control fields
`define AUX_MASK 16'h0f3f
`define AUX_BSEL_LSB 8
`define AUX_CSEL_LSB 2
`define AUX_CHOP_H 1
`define AUX_CHOP_L 0
`define SEL_W 4
`define SEL_FIRST_RSVD 4'h9
`define REG_RESET 16'h0000
`endif

// file: rtl/blank_chop_pkg.sv
package blank_chop_pkg;
  typedef enum logic [1:0] {
    BLANK_IDLE,
    BLANK_COUNT
  } blank_state_t;
endpackage

// file: rtl/pwm_blanking_chop_config.sv
`timescale 1ns/1ps
`include "blank_chop_defs.svh"
// Function
// - Delay register top four bits read zero and ignore writes.
// - Twelve-bit delay sets blanking length for current-limit and fault inputs.
// - State blanking only when select-high or select-low enable bit set.
// - Four-bit state-blank source select; codes 1001 and above reserved.
// - Chop source select gates enabled PWM outputs on and off.
module pwm_blanking_chop_config #(
  parameter int NSRC = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // PWM generator side
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  input wire logic [NSRC-1:0] state_blank_src_i,
  input wire logic [NSRC-1:0] chop_src_i,
  // Protection inputs from pins
  input wire logic cur_limit_i,
  input wire logic fault_i,
  // Outputs
  output logic pwm_high_output_o,
  output logic pwm_low_output_o,
  output logic cur_limit_o,
  output logic fault_o,
  output logic blanking_o
);

  // ==========================================
  // Registers
  logic [15:0] blanking_control_reg_q;
  logic [15:0] delay_q;
  logic [15:0] aux_q;
  logic [15:0] rdata_q;

  function automatic logic pick(input logic [NSRC-1:0] src, input logic [3:0] sel);
    logic r;
    r = 1'b0;
    if (sel < `SEL_FIRST_RSVD && 32'(sel) < NSRC)
    begin
      r = src[sel];
    end
    return r;
  endfunction

  function automatic logic rose(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  function automatic logic fell(input logic now, input logic prev);
    return ~now & prev;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      blanking_control_reg_q <= `REG_RESET;
      delay_q <= `REG_RESET;
      aux_q <= `REG_RESET;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `ADDR_BLANK_CTRL: blanking_control_reg_q <= wdata_i & `BC_MASK;
        `ADDR_BLANK_DELAY: delay_q <= wdata_i & `DLY_MASK;
        `ADDR_AUX_CTRL: aux_q <= wdata_i & `AUX_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q <= `REG_RESET;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `ADDR_BLANK_CTRL: rdata_q <= blanking_control_reg_q;
        `ADDR_BLANK_DELAY: rdata_q <= delay_q;
        `ADDR_AUX_CTRL: rdata_q <= aux_q;
        default: rdata_q <= `REG_RESET;
      endcase
    end
    else
    begin
      rdata_q <= `REG_RESET;
    end
  end
  assign rdata_o = rdata_q;

  // ==========================================
  // Input synchronisers
  logic [1:0] cl_s, flt_s;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cl_s <= 2'h0;
      flt_s <= 2'h0;
    end
    else
    begin
      cl_s <= {cl_s[0], cur_limit_i};
      flt_s <= {flt_s[0], fault_i};
    end
  end

  // ==========================================
  // Leading-edge blanking counter
  logic pwm_high_q, pwm_low_q, edge_hit;
  logic [`DLY_W-1:0] blank_delay_count;
  logic [`DLY_W-1:0] cnt_q;
  blank_chop_pkg::blank_state_t state_q;
  assign blank_delay_count = delay_q[`DLY_W-1:0];
  assign edge_hit = (blanking_control_reg_q[`BC_PHR] & rose(pwm_high_i, pwm_high_q))
                  | (blanking_control_reg_q[`BC_PHF] & fell(pwm_high_i, pwm_high_q))
                  | (blanking_control_reg_q[`BC_PLR] & rose(pwm_low_i, pwm_low_q))
                  | (blanking_control_reg_q[`BC_PLF] & fell(pwm_low_i, pwm_low_q));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_high_q <= 1'b0;
      pwm_low_q <= 1'b0;
      cnt_q <= '0;
      state_q <= blank_chop_pkg::BLANK_IDLE;
    end
    else
    begin
      pwm_high_q <= pwm_high_i;
      pwm_low_q <= pwm_low_i;
      case (state_q)
        blank_chop_pkg::BLANK_IDLE:
        begin
          if (edge_hit && blank_delay_count != '0)
          begin
            cnt_q <= '0;
            state_q <= blank_chop_pkg::BLANK_COUNT;
          end
        end
        blank_chop_pkg::BLANK_COUNT:
        begin
          if (edge_hit && blank_delay_count != '0)
          begin
            cnt_q <= '0;
          end
          else if (cnt_q + `DLY_W'(1) >= blank_delay_count)
          begin
            state_q <= blank_chop_pkg::BLANK_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q + `DLY_W'(1);
          end
        end
        default: state_q <= blank_chop_pkg::BLANK_IDLE;
      endcase
    end
  end

  // ==========================================
  // Blanking combination
  logic leb_active, sb_sig, state_blank, out_blank, cl_blank, flt_blank;
  assign leb_active = (state_q == blank_chop_pkg::BLANK_COUNT);
  assign sb_sig = pick(state_blank_src_i, aux_q[`AUX_BSEL_LSB +: `SEL_W]);
  assign state_blank = (blanking_control_reg_q[`BC_SEL_HIGH] & sb_sig)
                     | (blanking_control_reg_q[`BC_SEL_LOW] & ~sb_sig);
  assign out_blank = (blanking_control_reg_q[`BC_BPHH] & pwm_high_i)
                   | (blanking_control_reg_q[`BC_BPHL] & ~pwm_high_i)
                   | (blanking_control_reg_q[`BC_BPLH] & pwm_low_i)
                   | (blanking_control_reg_q[`BC_BPLL] & ~pwm_low_i);
  assign cl_blank = (leb_active & blanking_control_reg_q[`BC_CL_EN]) | state_blank | out_blank;
  assign flt_blank = (leb_active & blanking_control_reg_q[`BC_FLT_EN]) | state_blank | out_blank;

  // ==========================================
  // Protection outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cur_limit_o <= 1'b0;
      fault_o <= 1'b0;
      blanking_o <= 1'b0;
    end
    else
    begin
      cur_limit_o <= cl_s[1] & ~cl_blank;
      fault_o <= flt_s[1] & ~flt_blank;
      blanking_o <= leb_active | state_blank;
    end
  end

  // ==========================================
  // Chopped PWM outputs
  logic chop_sig;
  assign chop_sig = pick(chop_src_i, aux_q[`AUX_CSEL_LSB +: `SEL_W]);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_high_output_o <= 1'b0;
      pwm_low_output_o <= 1'b0;
    end
    else
    begin
      pwm_high_output_o <= pwm_high_i & (~aux_q[`AUX_CHOP_H] | chop_sig);
      pwm_low_output_o <= pwm_low_i & (~aux_q[`AUX_CHOP_L] | chop_sig);
    end
  end

endmodule

// file: tb/pwm_blanking_chop_config_properties.sv
`timescale 1ns/1ps
module pwm_blanking_chop_config_properties (
  // Watched ports
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  input wire logic cur_limit_i,
  input wire logic fault_i,
  input wire logic pwm_high_output_o,
  input wire logic pwm_low_output_o,
  input wire logic cur_limit_o,
  input wire logic fault_o,
  input wire logic blanking_o
);
  // ====
  // Output-state blanking bits as last written
  logic [3:0] obits_q;
  logic no_blank;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      obits_q <= 4'h0;
    end
    else if (wr_i && addr_i == 4'h0)
    begin
      obits_q <= wdata_i[3:0];
    end
  end
  assign no_blank = !blanking_o && obits_q == 4'h0;
  // ====
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_delay_top_zero: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[15:12] == 4'h0)
    else $error("delay top bits set");
  a_aux_top_zero: assert property (rd_i && addr_i == 4'h2 |=> rdata_o[15:12] == 4'h0)
    else $error("aux top bits set");
  a_high_gated: assert property (!pwm_high_i |=> !pwm_high_output_o)
    else $error("high output on");
  a_low_gated: assert property (!pwm_low_i |=> !pwm_low_output_o)
    else $error("low output on");
  a_limit_cause: assert property (cur_limit_o |-> $past(cur_limit_i, 3))
    else $error("limit without pin");
  a_fault_cause: assert property (fault_o |-> $past(fault_i, 3))
    else $error("fault without pin");
  a_limit_pass: assert property ((cur_limit_i && no_blank)[*6] |-> cur_limit_o)
    else $error("limit lost");
  a_fault_pass: assert property ((fault_i && no_blank)[*6] |-> fault_o)
    else $error("fault lost");
  c_read: cover property (rd_i);
  c_blank: cover property ($rose(blanking_o));
  c_limit: cover property (cur_limit_o);
endmodule
bind pwm_blanking_chop_config pwm_blanking_chop_config_properties u_props (.clk_i, .sys_rst_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pwm_high_i, .pwm_low_i, .cur_limit_i, .fault_i,
  .pwm_high_output_o, .pwm_low_output_o, .cur_limit_o, .fault_o, .blanking_o);

// file: tb/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  input wire logic clk_i,
  input wire logic high_i,
  input wire logic low_i,
  output logic over_cur_o
);
  // Over-current level, held for as long as either output is on
  always_ff @(posedge clk_i) over_cur_o <= high_i | low_i;
endmodule

// file: tb/test_pwm_blanking_chop_config.sv
`timescale 1ns/1ps
`include "blank_chop_defs.svh"
`define CHK(s,e,a) begin compares++; if ((a) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", s, e, a); end end
module test_pwm_blanking_chop_config;
  logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, ph = 0, pl = 0, flt = 0;
  logic [3:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o;
  logic [8:0] sb = 0, cs = 0;
  logic hi, lo, cl, clo, fo, bl;
  int compares = 0, miscompares = 0;
  logic [7:0] n;
  always #4 clk_i = ~clk_i;
  pwm_blanking_chop_config u_pwm_blanking_chop_config (.clk_i, .sys_rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pwm_high_i(ph), .pwm_low_i(pl), .state_blank_src_i(sb),
    .chop_src_i(cs), .cur_limit_i(cl), .fault_i(flt), .pwm_high_output_o(hi),
    .pwm_low_output_o(lo), .cur_limit_o(clo), .fault_o(fo), .blanking_o(bl));
  power_stage_model u_power_stage_model (.clk_i, .high_i(hi), .low_i(lo), .over_cur_o(cl));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    cyc(1);
    rd_i <= 1'h0;
    cyc(1);
    `CHK("rdata_o", e, rdata_o)
  endtask
  // ====
  // Scenarios
  task automatic reg_test;
    wr(`ADDR_BLANK_DELAY, 16'hffff);
    rd(`ADDR_BLANK_DELAY, 16'h0fff);
    wr(`ADDR_AUX_CTRL, 16'hffff);
    rd(`ADDR_AUX_CTRL, 16'h0f3f);
    rd(4'h3, 16'h0000);
  endtask
  task automatic chop_test;
    wr(`ADDR_AUX_CTRL, 16'h000f);
    ph <= 1'h1;
    pl <= 1'h1;
    cs <= 9'h008;
    cyc(3);
    `CHK("pwm_high_output_o", 1'h1, hi)
    `CHK("pwm_low_output_o", 1'h1, lo)
    cs <= 9'h000;
    cyc(3);
    `CHK("pwm_high_output_o", 1'h0, hi)
    `CHK("pwm_low_output_o", 1'h0, lo)
    wr(`ADDR_AUX_CTRL, 16'h000d);
    cyc(2);
    `CHK("pwm_high_output_o", 1'h1, hi)
    `CHK("pwm_low_output_o", 1'h0, lo)
    ph <= 1'h0;
    pl <= 1'h0;
  endtask
  task automatic leb_test;
    wr(`ADDR_BLANK_CTRL, 16'h8400);
    wr(`ADDR_BLANK_DELAY, 16'h000c);
    ph <= 1'h1;
    n = 8'h00;
    repeat (8) @(posedge clk_i) n = n + {7'h00, bl};
    `CHK("cur_limit_o", 1'h0, clo)
    repeat (22) @(posedge clk_i) n = n + {7'h00, bl};
    `CHK("blank cycles", 8'h0c, n)
    `CHK("cur_limit_o", 1'h1, clo)
    ph <= 1'h0;
  endtask
  task automatic leb_fall_test;
    wr(`ADDR_BLANK_CTRL, 16'h1800);
    pl <= 1'h1;
    cyc(4);
    `CHK("blanking_o", 1'h0, bl)
    pl <= 1'h0;
    flt <= 1'h1;
    n = 8'h00;
    repeat (8) @(posedge clk_i) n = n + {7'h00, bl};
    `CHK("fault_o", 1'h0, fo)
    repeat (22) @(posedge clk_i) n = n + {7'h00, bl};
    `CHK("blank cycles", 8'h0c, n)
    `CHK("fault_o", 1'h1, fo)
  endtask
  task automatic state_test;
    wr(`ADDR_BLANK_CTRL, 16'h0c20);
    wr(`ADDR_AUX_CTRL, 16'h0200);
    sb <= 9'h004;
    flt <= 1'h1;
    cyc(6);
    `CHK("fault_o", 1'h0, fo)
    sb <= 9'h000;
    cyc(6);
    `CHK("fault_o", 1'h1, fo)
    wr(`ADDR_AUX_CTRL, 16'h0900);
    sb <= 9'h1ff;
    cyc(6);
    `CHK("fault_o", 1'h1, fo)
    wr(`ADDR_BLANK_CTRL, 16'h0c00);
    wr(`ADDR_AUX_CTRL, 16'h0200);
    cyc(6);
    `CHK("fault_o", 1'h1, fo)
    wr(`ADDR_BLANK_CTRL, 16'h0c10);
    sb <= 9'h000;
    cyc(6);
    `CHK("fault_o", 1'h0, fo)
    `CHK("blanking_o", 1'h1, bl)
  endtask
  task automatic stop_test;
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(16);
    sys_rst_i <= 1'h0;
    reg_test;
    chop_test;
    leb_test;
    leb_fall_test;
    state_test;
    stop_test;
  end
  initial
  begin
    cyc(2000);
    miscompares++;
    stop_test;
  end
endmodule
